/* hdl/eep_pkg.sv */
package eep_pkg;

  // Array geometry
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 8;
  localparam int PAGE_W     = 3;
  localparam int MEM_DEPTH  = 256;
  localparam int PAGE_BYTES = 8;
  localparam int MSB        = DATA_W - 1;

  // Device address word fields
  localparam logic [3:0] DEV_PREFIX = 4'h a;
  localparam int         PFX_HI     = 7;
  localparam int         PFX_LO     = 4;
  localparam int         STRAP_HI   = 3;
  localparam int         STRAP_LO   = 1;
  localparam int         DIR_BIT    = 0;

  // Bit counter positions within a nine-clock word
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_LAST  = 4'h7;
  localparam logic [3:0] BIT_ACK   = 4'h8;
  localparam logic [3:0] BIT_STEP  = 4'h1;

  // Self-timed write cycle, longest time rounded down
  localparam int CORE_CLK_KHZ = 50000;
  localparam int T_WR_MS      = 5;
  localparam int T_WR_CYCLES  = T_WR_MS * CORE_CLK_KHZ;

  // Link-side protocol states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEV,
    ST_WADDR,
    ST_WDATA,
    ST_RDATA
  } eep_state_type;

endpackage

/* hdl/eep_slave.sv */
`timescale 1ns/1ns
`default_nettype none
module eep_slave #(
  parameter int WR_CYCLES = eep_pkg::T_WR_CYCLES
) (
  // Clocks and reset
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic scl_clk,
  // Serial data pin, open drain
  input  wire logic sda_in,
  output var  logic sda_out,
  output var  logic sda_oe,
  // Straps and write lock
  input  wire logic addr_strap_2,
  input  wire logic addr_strap_1,
  input  wire logic addr_strap_0,
  input  wire logic write_lock_pin,
  // Status
  output var  logic standby,
  output var  logic write_busy
);

  localparam int                  WCNT_W  = $clog2(WR_CYCLES + 1);
  localparam logic [WCNT_W-1:0]   WR_LAST = WCNT_W'(WR_CYCLES - 1);
  localparam logic [WCNT_W-1:0]   WR_ONE  = WCNT_W'(1);
  localparam logic [WCNT_W-1:0]   WR_ZERO = WCNT_W'(0);

  // Core domain state
  logic [eep_pkg::MSB:0]   mem_reg [eep_pkg::MEM_DEPTH];
  logic                    scl_m_reg, scl_s_reg, scl_d_reg;
  logic                    sda_m_reg, sda_s_reg, sda_d_reg;
  logic                    lock_m_reg, lock_s_reg;
  logic                    frame_m_reg, frame_s_reg, frame_done_reg;
  logic                    sel_m_reg, sel_s_reg, sel_d_reg;
  logic                    nom_m_reg, nom_s_reg, nom_d_reg;
  logic                    link_rst_reg;
  logic [WCNT_W-1:0]       wr_cnt_reg;
  logic                    stop_evt;
  logic                    commit;
  logic                    do_write;
  logic                    wr_done;

  // Link domain state
  eep_pkg::eep_state_type  st_reg;
  logic [3:0]              bit_cnt_reg;
  logic [eep_pkg::MSB:0]   shift_reg;
  logic [eep_pkg::MSB:0]   tx_reg;
  logic [eep_pkg::ADDR_W-1:0] addr_reg;
  logic                    dir_reg;
  logic [eep_pkg::MSB:0]   page_buf_reg [eep_pkg::PAGE_BYTES];
  logic [eep_pkg::PAGE_BYTES-1:0] mask_reg;
  logic [eep_pkg::ADDR_W-eep_pkg::PAGE_W-1:0] page_reg;
  logic                    frame_tog_reg;
  logic                    sel_reg;
  logic                    nomatch_reg;
  logic                    rx_bit_reg;
  logic                    busy_m_reg, busy_s_reg;
  logic [2:0]              strap_m_reg, strap_s_reg;
  logic                    start_evt;
  logic                    stop_link;
  logic                    match;
  logic [eep_pkg::MSB:0]   byte_in;
  logic [eep_pkg::MSB:0]   rd_byte;

  // Two-stage synchronisers into the core clock
  always_ff @(posedge core_clk) begin
    if (rst) begin
      {scl_s_reg, scl_m_reg}     <= 2'h3;
      {sda_s_reg, sda_m_reg}     <= 2'h3;
      {lock_s_reg, lock_m_reg}   <= 2'h0;
      {frame_s_reg, frame_m_reg} <= 2'h0;
      {sel_s_reg, sel_m_reg}     <= 2'h0;
      {nom_s_reg, nom_m_reg}     <= 2'h0;
      scl_d_reg                  <= 1'b1;
      sda_d_reg                  <= 1'b1;
      sel_d_reg                  <= 1'b0;
      nom_d_reg                  <= 1'b0;
    end else begin
      {scl_s_reg, scl_m_reg}     <= {scl_m_reg, scl_clk};
      {sda_s_reg, sda_m_reg}     <= {sda_m_reg, sda_in};
      {lock_s_reg, lock_m_reg}   <= {lock_m_reg, write_lock_pin};
      {frame_s_reg, frame_m_reg} <= {frame_m_reg, frame_tog_reg};
      {sel_s_reg, sel_m_reg}     <= {sel_m_reg, sel_reg};
      {nom_s_reg, nom_m_reg}     <= {nom_m_reg, nomatch_reg};
      scl_d_reg                  <= scl_s_reg;
      sda_d_reg                  <= sda_s_reg;
      sel_d_reg                  <= sel_s_reg;
      nom_d_reg                  <= nom_s_reg;
    end
  end

  // Stop seen on settled lines; clock high in both samples while data rises
  assign stop_evt = scl_s_reg & scl_d_reg & sda_s_reg & ~sda_d_reg;
  // One commit per write frame, never while the cycle still runs
  assign commit   = stop_evt & ~write_busy & (frame_s_reg != frame_done_reg);
  // Page buffer and mask are frozen after the stop until the next matched address byte
  assign do_write = commit & ~lock_s_reg & (|mask_reg);
  assign wr_done  = write_busy & (wr_cnt_reg == WR_LAST);

  // Reset handed to the link logic; link clock is idle in reset
  always_ff @(posedge core_clk) begin
    link_rst_reg <= rst;
    sda_out      <= 1'b0;
  end

  // Self-timed write cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      write_busy     <= 1'b0;
      wr_cnt_reg     <= WR_ZERO;
      frame_done_reg <= 1'b0;
    end else begin
      if (stop_evt & ~write_busy) begin
        frame_done_reg <= frame_s_reg;
      end
      if (do_write) begin
        write_busy <= 1'b1;
        wr_cnt_reg <= WR_ZERO;
      end else if (write_busy) begin
        wr_cnt_reg <= wr_cnt_reg + WR_ONE;
        if (wr_done) begin
          write_busy <= 1'b0;
        end
      end
    end
  end

  // Array update, only the bytes the master actually sent
  always_ff @(posedge core_clk) begin
    if (do_write) begin
      for (int i = 0; i < eep_pkg::PAGE_BYTES; i++) begin
        if (mask_reg[i]) begin
          mem_reg[{page_reg, eep_pkg::PAGE_W'(i)}] <= page_buf_reg[i];
        end
      end
    end
  end

  // Standby tracking
  always_ff @(posedge core_clk) begin
    if (rst) begin
      standby <= 1'b1;
    end else if (wr_done) begin
      standby <= 1'b1;
    end else if (stop_evt & ~do_write) begin
      standby <= 1'b1;
    end else if (sel_s_reg & ~sel_d_reg) begin
      standby <= 1'b0;
    end else if (nom_s_reg & ~nom_d_reg) begin
      standby <= 1'b1;
    end
  end

  // Link side: sampling on the rising clock edge
  always_ff @(posedge scl_clk or posedge link_rst_reg) begin
    if (link_rst_reg) begin
      rx_bit_reg  <= 1'b1;
      busy_m_reg  <= 1'b0;
      busy_s_reg  <= 1'b0;
      strap_m_reg <= 3'h0;
      strap_s_reg <= 3'h0;
    end else begin
      rx_bit_reg  <= sda_in;
      busy_m_reg  <= write_busy;
      busy_s_reg  <= busy_m_reg;
      strap_m_reg <= {addr_strap_2, addr_strap_1, addr_strap_0};
      strap_s_reg <= strap_m_reg;
    end
  end

  // Data moving while the clock is high marks start or stop
  assign start_evt = rx_bit_reg & ~sda_in;
  assign stop_link = ~rx_bit_reg & sda_in;
  assign byte_in   = {shift_reg[eep_pkg::MSB-1:0], rx_bit_reg};
  // Array is static outside the write cycle, when reads are refused
  assign rd_byte   = mem_reg[addr_reg];
  assign match     = (byte_in[eep_pkg::PFX_HI:eep_pkg::PFX_LO] == eep_pkg::DEV_PREFIX)
                   & (byte_in[eep_pkg::STRAP_HI:eep_pkg::STRAP_LO] == strap_s_reg)
                   & ~busy_s_reg;

  // Link side protocol engine; SDA only moves on the falling edge
  always_ff @(negedge scl_clk or posedge link_rst_reg) begin
    if (link_rst_reg) begin
      st_reg        <= eep_pkg::ST_IDLE;
      bit_cnt_reg   <= eep_pkg::BIT_FIRST;
      shift_reg     <= 8'h00;
      tx_reg        <= 8'h00;
      addr_reg      <= 8'h00;
      dir_reg       <= 1'b0;
      sda_oe        <= 1'b0;
      mask_reg      <= 8'h00;
      page_reg      <= 5'h00;
      frame_tog_reg <= 1'b0;
      sel_reg       <= 1'b0;
      nomatch_reg   <= 1'b0;
    end else if (start_evt) begin
      st_reg      <= eep_pkg::ST_DEV;
      bit_cnt_reg <= eep_pkg::BIT_FIRST;
      sda_oe      <= 1'b0;
      sel_reg     <= 1'b0;
      nomatch_reg <= 1'b0;
    end else if (stop_link) begin
      st_reg      <= eep_pkg::ST_IDLE;
      bit_cnt_reg <= eep_pkg::BIT_FIRST;
      sda_oe      <= 1'b0;
    end else begin
      case (st_reg)
        eep_pkg::ST_IDLE: begin
          sda_oe <= 1'b0;
        end
        eep_pkg::ST_RDATA: begin
          if (bit_cnt_reg < eep_pkg::BIT_LAST) begin
            tx_reg      <= {tx_reg[eep_pkg::MSB-1:0], 1'b0};
            sda_oe      <= ~tx_reg[eep_pkg::MSB-1];
            bit_cnt_reg <= bit_cnt_reg + eep_pkg::BIT_STEP;
          end else if (bit_cnt_reg == eep_pkg::BIT_LAST) begin
            sda_oe      <= 1'b0;
            bit_cnt_reg <= eep_pkg::BIT_ACK;
          end else if (!rx_bit_reg) begin
            tx_reg      <= rd_byte;
            sda_oe      <= ~rd_byte[eep_pkg::MSB];
            addr_reg    <= addr_reg + 8'h01;
            bit_cnt_reg <= eep_pkg::BIT_FIRST;
          end else begin
            st_reg <= eep_pkg::ST_IDLE;
          end
        end
        eep_pkg::ST_DEV, eep_pkg::ST_WADDR, eep_pkg::ST_WDATA: begin
          if (bit_cnt_reg < eep_pkg::BIT_LAST) begin
            shift_reg   <= byte_in;
            bit_cnt_reg <= bit_cnt_reg + eep_pkg::BIT_STEP;
          end else if (bit_cnt_reg == eep_pkg::BIT_LAST) begin
            bit_cnt_reg <= eep_pkg::BIT_ACK;
            if (st_reg == eep_pkg::ST_DEV) begin
              if (match) begin
                sda_oe   <= 1'b1;
                sel_reg  <= 1'b1;
                dir_reg  <= byte_in[eep_pkg::DIR_BIT];
                mask_reg <= 8'h00;
                if (!byte_in[eep_pkg::DIR_BIT]) begin
                  frame_tog_reg <= ~frame_tog_reg;
                end
              end else begin
                nomatch_reg <= 1'b1;
                st_reg      <= eep_pkg::ST_IDLE;
              end
            end else if (st_reg == eep_pkg::ST_WADDR) begin
              sda_oe   <= 1'b1;
              addr_reg <= byte_in;
            end else begin
              sda_oe   <= 1'b1;
              page_buf_reg[addr_reg[eep_pkg::PAGE_W-1:0]] <= byte_in;
              mask_reg[addr_reg[eep_pkg::PAGE_W-1:0]]     <= 1'b1;
              page_reg <= addr_reg[eep_pkg::ADDR_W-1:eep_pkg::PAGE_W];
            end
          end else begin
            sda_oe      <= 1'b0;
            bit_cnt_reg <= eep_pkg::BIT_FIRST;
            if (st_reg == eep_pkg::ST_DEV) begin
              if (dir_reg) begin
                st_reg   <= eep_pkg::ST_RDATA;
                tx_reg   <= rd_byte;
                sda_oe   <= ~rd_byte[eep_pkg::MSB];
                addr_reg <= addr_reg + 8'h01;
              end else begin
                st_reg <= eep_pkg::ST_WADDR;
              end
            end else if (st_reg == eep_pkg::ST_WADDR) begin
              st_reg <= eep_pkg::ST_WDATA;
            end else begin
              addr_reg <= {addr_reg[eep_pkg::ADDR_W-1:eep_pkg::PAGE_W],
                           addr_reg[eep_pkg::PAGE_W-1:0] + 3'h1};
            end
          end
        end
        default: begin
          st_reg <= eep_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Core domain checks
  a_stop_busy: assert property (@(posedge core_clk) disable iff (rst)
    do_write |=> write_busy ##1 write_busy)
    else $error("write cycle did not start after stop");
  a_busy_len: assert property (@(posedge core_clk) disable iff (rst)
    $fell(write_busy) |-> $past(wr_cnt_reg) == WR_LAST)
    else $error("write cycle length wrong");
  a_lock_blocks: assert property (@(posedge core_clk) disable iff (rst)
    stop_evt && lock_s_reg && !write_busy |=> !write_busy)
    else $error("write started while locked");
  a_done_standby: assert property (@(posedge core_clk) disable iff (rst)
    $fell(write_busy) |-> standby)
    else $error("no standby after write cycle");

  // Link domain checks; start and stop excluded except in a_start_abort, they override the word logic
  a_addr_ack: assert property (@(negedge scl_clk) disable iff (link_rst_reg)
    st_reg == eep_pkg::ST_DEV && bit_cnt_reg == eep_pkg::BIT_LAST && !start_evt
    && !stop_link && match && !byte_in[eep_pkg::DIR_BIT]
    |=> sda_oe ##1 !sda_oe)
    else $error("address acknowledge not one clock");
  a_addr_nack: assert property (@(negedge scl_clk) disable iff (link_rst_reg)
    st_reg == eep_pkg::ST_DEV && bit_cnt_reg == eep_pkg::BIT_LAST && !start_evt
    && !stop_link && !match |=> !sda_oe && st_reg == eep_pkg::ST_IDLE)
    else $error("mismatched address acknowledged");
  a_busy_nack: assert property (@(negedge scl_clk) disable iff (link_rst_reg)
    busy_s_reg && st_reg == eep_pkg::ST_DEV && bit_cnt_reg == eep_pkg::BIT_LAST
    && !start_evt && !stop_link |=> !sda_oe)
    else $error("acknowledged during write cycle");
  a_page_wrap: assert property (@(negedge scl_clk) disable iff (link_rst_reg)
    st_reg == eep_pkg::ST_WDATA && bit_cnt_reg == eep_pkg::BIT_ACK && !start_evt
    && !stop_link
    |=> addr_reg[eep_pkg::ADDR_W-1:eep_pkg::PAGE_W]
        == $past(addr_reg[eep_pkg::ADDR_W-1:eep_pkg::PAGE_W])
    && addr_reg[eep_pkg::PAGE_W-1:0] == $past(addr_reg[eep_pkg::PAGE_W-1:0]) + 3'h1)
    else $error("page address step wrong");
  a_read_inc: assert property (@(negedge scl_clk) disable iff (link_rst_reg)
    st_reg == eep_pkg::ST_RDATA && bit_cnt_reg == eep_pkg::BIT_ACK && !start_evt
    && !stop_link && !rx_bit_reg
    |=> addr_reg == $past(addr_reg) + 8'h01
    && sda_oe == !$past(rd_byte[eep_pkg::MSB]))
    else $error("sequential read step wrong");
  // Read entry takes the counter's byte and steps the counter once
  a_read_entry: assert property (@(negedge scl_clk) disable iff (link_rst_reg)
    st_reg == eep_pkg::ST_DEV && bit_cnt_reg == eep_pkg::BIT_ACK && dir_reg
    && !start_evt && !stop_link
    |=> st_reg == eep_pkg::ST_RDATA && addr_reg == $past(addr_reg) + 8'h01
    && sda_oe == !$past(rd_byte[eep_pkg::MSB]))
    else $error("read did not start at counter");
  a_start_abort: assert property (@(negedge scl_clk) disable iff (link_rst_reg)
    start_evt |=> st_reg == eep_pkg::ST_DEV && bit_cnt_reg == eep_pkg::BIT_FIRST
    && !sda_oe)
    else $error("start did not restart transfer");
  a_ack_release: assert property (@(negedge scl_clk) disable iff (link_rst_reg)
    st_reg == eep_pkg::ST_RDATA && bit_cnt_reg == eep_pkg::BIT_LAST && !start_evt
    && !stop_link |=> !sda_oe)
    else $error("data line held in master acknowledge");

  // Main scenarios: commit, sequential read, busy poll, in-page wrap
  c_write_commit: cover property (@(posedge core_clk) disable iff (rst) do_write);
  c_page_wrap: cover property (@(negedge scl_clk) disable iff (link_rst_reg)
    st_reg == eep_pkg::ST_WDATA && bit_cnt_reg == eep_pkg::BIT_ACK
    && addr_reg[eep_pkg::PAGE_W-1:0] == '1);
  c_read_next: cover property (@(negedge scl_clk) disable iff (link_rst_reg)
    st_reg == eep_pkg::ST_RDATA && bit_cnt_reg == eep_pkg::BIT_ACK && !rx_bit_reg);
  c_poll_nack: cover property (@(negedge scl_clk) disable iff (link_rst_reg)
    busy_s_reg && st_reg == eep_pkg::ST_DEV && bit_cnt_reg == eep_pkg::BIT_LAST);

endmodule // eep_slave
`default_nettype wire

/* tb/eep_master.sv */
`timescale 1ns/1ns
`default_nettype none
module eep_master (
  // Two-wire bus
  output var  logic scl_clk,
  output var  logic sda_m,
  input  wire logic sda
);
  localparam int HALF = 32;

  // Idle bus: clock high, data released to the pull-up
  initial begin
    scl_clk = 1'b1;
    sda_m   = 1'b1;
  end

  // One clock; data moves 10 ns after the fall, never near an edge
  task automatic bit_out(input logic b, output logic s);
    #10 sda_m = b;
    #(HALF - 10) scl_clk = 1'b1;
    s = sda;
    #HALF scl_clk = 1'b0;
  endtask

  // Clock dropped first so a start from idle also has a rise with data high
  task automatic start;
    #10 scl_clk = 1'b0;
    #10 sda_m = 1'b1;
    #22 scl_clk = 1'b1;
    #HALF sda_m = 1'b0;
    #HALF scl_clk = 1'b0;
  endtask

  // Stop is seen at the following fall, so the clock pulses once more
  task automatic stop;
    #10 sda_m = 1'b0;
    #22 scl_clk = 1'b1;
    #HALF sda_m = 1'b1;
    #HALF scl_clk = 1'b0;
    #HALF scl_clk = 1'b1;
  endtask

  // Byte out, most significant bit first, ninth clock reads the answer
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    int   i;
    for (i = 7; i >= 0; i--) bit_out(d[i], s);
    bit_out(1'b1, s);
    ack = ~s;
  endtask

  // Byte in; master acknowledge asks for the next byte
  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic s;
    int   i;
    for (i = 0; i < 8; i++) begin
      bit_out(1'b1, s);
      d = {d[6:0], s};
    end
    bit_out(~mack, s);
  endtask
endmodule // eep_master
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam int WR    = 100;
  localparam int LIMIT = 20000;
  // Pins
  logic       core_clk;
  logic       rst;
  logic       lock;
  logic [2:0] strap;
  wire  logic scl;
  wire  logic sda_m;
  wire  logic sda;
  wire  logic sda_oe;
  wire  logic sda_out;
  wire  logic standby;
  wire  logic busy;
  // Reference model and bookkeeping
  int         mem [256];
  int         ctr;
  int         seed = 42;
  int         cyc = 0;
  int         mismatches = 0;
  int         n_checks = 0;
  int         j;
  logic       k;
  logic [7:0] bad [4];

  // Open-drain wire with pull-up
  assign sda = sda_m & ~(sda_oe & ~sda_out);

  eep_master m (
    .scl_clk (scl),
    .sda_m   (sda_m),
    .sda     (sda)
  );

  eep_slave #(.WR_CYCLES(WR)) DUT (
    .core_clk       (core_clk),
    .rst            (rst),
    .scl_clk        (scl),
    .sda_in         (sda),
    .sda_out        (sda_out),
    .sda_oe         (sda_oe),
    .addr_strap_2   (strap[2]),
    .addr_strap_1   (strap[1]),
    .addr_strap_0   (strap[0]),
    .write_lock_pin (lock),
    .standby        (standby),
    .write_busy     (busy)
  );

  // Core clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      mismatches++;
      results();
    end
  end

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Settled sampling point, away from the core edge
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  function automatic logic [7:0] dev(input logic rd);
    return {4'ha, strap, rd};
  endfunction

  task automatic addr(input logic [7:0] a, input logic exp_ack);
    m.start();
    m.wbyte(a, k);
    chk(8'(k), 8'(exp_ack));
  endtask

  // Page write; low three address bits wrap, locked writes leave the array alone
  task automatic wpage(input logic [7:0] wa, input int n);
    logic [7:0] d;
    logic [7:0] a;
    int         i;
    addr(dev(1'b0), 1'b1);
    m.wbyte(wa, k);
    chk(8'(k), 8'h1);
    a = wa;
    for (i = 0; i < n; i++) begin
      d = 8'($random(seed));
      m.wbyte(d, k);
      chk(8'(k), 8'h1);
      if (lock !== 1'b1) mem[a] = int'(d);
      a = {a[7:3], a[2:0] + 3'h1};
    end
    m.stop();
    ctr = int'(a);
  endtask

  // Self-timed cycle: busy, one poll refused, then answered
  task automatic wcycle;
    int t0;
    int i;
    t0 = cyc;
    idle(10);
    chk(8'(busy), 8'h1);
    addr(dev(1'b0), 1'b0);
    m.stop();
    i = 0;
    while (busy !== 1'b0 && i < 400) begin
      idle(1);
      i++;
    end
    chk(8'(cyc - t0 >= WR - 2 && cyc - t0 <= WR + 8), 8'h1);
    chk(8'(standby), 8'h1);
    idle(10);
    addr(dev(1'b0), 1'b1);
    m.stop();
    idle(10);
  endtask

  task automatic rread(input int n);
    logic [7:0] d;
    int         i;
    addr(dev(1'b1), 1'b1);
    for (i = 0; i < n; i++) begin
      m.rbyte(i != n - 1, d);
      chk(d, 8'(mem[ctr]));
      if (i == 0) chk(8'(standby), 8'h0);
      ctr = (ctr + 1) % 256;
    end
    m.stop();
    idle(10);
    chk(8'(standby), 8'h1);
  endtask

  // Dummy write of the word address, then a repeated start
  task automatic rrand(input logic [7:0] wa, input int n);
    addr(dev(1'b0), 1'b1);
    m.wbyte(wa, k);
    chk(8'(k), 8'h1);
    ctr = int'(wa);
    rread(n);
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    lock = 1'b0;
    strap = 3'($random(seed));
    bad = '{{4'hb, strap, 1'b0}, {4'h2, strap, 1'b1},
            {4'ha, strap ^ 3'h1, 1'b0}, {4'ha, strap ^ 3'h4, 1'b1}};
    repeat (2) @(posedge core_clk);
    @(negedge core_clk) rst = 1'b0;
    idle(5);
    chk(8'({standby, busy, sda_oe}), 8'h4);
    for (j = 0; j < 4; j++) begin
      addr(bad[j], 1'b0);
      m.stop();
      idle(10);
      chk(8'(standby), 8'h1);
    end
    wpage(8'h13, 10);
    wcycle();
    wpage(8'hfe, 2);
    wcycle();
    wpage(8'h00, 2);
    wcycle();
    rrand(8'h10, 8);
    rrand(8'hfe, 3);
    rread(1);
    // Locked write is acknowledged but never committed
    @(negedge core_clk) lock = 1'b1;
    wpage(8'h10, 2);
    idle(20);
    chk(8'(busy), 8'h0);
    @(negedge core_clk) lock = 1'b0;
    rrand(8'h10, 2);
    // Data byte cut short by a stop
    addr(dev(1'b0), 1'b1);
    m.wbyte(8'h20, k);
    chk(8'(k), 8'h1);
    for (j = 0; j < 4; j++) m.bit_out(1'b0, k);
    m.stop();
    idle(10);
    chk(8'(busy), 8'h0);
    // Recovery sequence, then a start inside an address byte
    m.start();
    for (j = 0; j < 9; j++) m.bit_out(1'b1, k);
    m.start();
    m.stop();
    idle(10);
    m.start();
    for (j = 0; j < 3; j++) m.bit_out(1'b1, k);
    rrand(8'h13, 1);
    results();
  end
endmodule // tb
`default_nettype wire
